// file: logic/amp_gain_limiter_control.sv
// Contract
// - Strap: supply disables limiting, resistor supply tracking, ground level
// - Trip voltage from eleven-entry resistor table, 3.7 V down to 2.8 V
// - Below trip voltage, compress when swing exceeds supply-derived limit
// - Attack lowers gain 1 dB per 20 us, stops under limit or at 6 dB
// - Release raises gain 0.5 dB per 800 ms while swing stays under limit
// - First attack after a release, still compressed, uses 0.5 dB steps
// - Level mode always limits at 90 % of boosted rail, same timing
// - Gain strap low 6 dB, floating 15.5 dB, high 20 dB
// - Both shutdown inputs low disable amplifier and enter low-current state
`timescale 1ns/1ps
`default_nettype none
module amp_gain_limiter_control
  import amp_limit_pkg::*;
#(
  parameter int ATTACK_CYC  = ATTACK_CYCLES,
  parameter int RELEASE_CYC = RELEASE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Pins, asynchronous to clk
  input  wire afe_flags_t  afe_flags,
  input  wire logic [3:0]  trip_resistor_index,
  input  wire logic        regulator_off_n,
  input  wire logic        amplifier_off_n,
  // Results
  output ctl_status_t      status,
  output logic [4:0]       gain_reduction_half_db,
  output logic             amp_enable
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  localparam int SW = $bits(afe_flags_t) + 6;
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {afe_flags, trip_resistor_index, regulator_off_n,
                 amplifier_off_n};
      sync_q <= meta_q;
    end
  end

  afe_flags_t flags;
  logic [3:0] trip_idx;
  logic       reg_on_n;
  logic       amp_on_n;
  assign {flags, trip_idx, reg_on_n, amp_on_n} = sync_q;

  ////////////////////////////////////////////////////////////////////////
  // Strap decode

  function automatic limit_mode_t decode_mode(input afe_flags_t f);
    if (f.strap_at_supply) begin
      decode_mode = MODE_OFF;
    end else if (f.strap_at_ground) begin
      decode_mode = MODE_LEVEL;
    end else begin
      decode_mode = MODE_SUPPLY;
    end
  endfunction : decode_mode

  function automatic gain_sel_t decode_gain(input afe_flags_t f);
    if (f.gain_strap_high) begin
      decode_gain = GAIN_20DB;
    end else if (f.gain_strap_low) begin
      decode_gain = GAIN_6DB;
    end else begin
      decode_gain = GAIN_15P5DB;
    end
  endfunction : decode_gain

  limit_mode_t mode;
  gain_sel_t   gain;
  logic        shutdown;
  logic        over_limit;
  logic        limiting;
  logic [3:0]  trip_sel;

  assign mode     = decode_mode(flags);
  assign gain     = decode_gain(flags);
  assign shutdown = !reg_on_n && !amp_on_n;
  // Out-of-table resistor clamps to the lowest trip point
  assign trip_sel = (trip_idx > 4'(TRIP_ENTRIES - 1)) ?
                    4'(TRIP_ENTRIES - 1) : trip_idx;

  always_comb begin
    limiting   = 1'b0;
    over_limit = 1'b0;
    case (mode)
      MODE_SUPPLY: begin
        limiting   = flags.supply_below_trip;
        over_limit = flags.supply_below_trip &&
                     flags.swing_over_supply_limit;
      end
      MODE_LEVEL: begin
        limiting   = 1'b1;
        over_limit = flags.swing_over_rail_limit;
      end
      default: begin
        limiting   = 1'b0;
        over_limit = 1'b0;
      end
    endcase
  end

  logic enabled;
  assign enabled = (mode != MODE_OFF) && !shutdown;

  ////////////////////////////////////////////////////////////////////////
  // Step timers

  comp_state_t state_q;
  comp_state_t state_d;
  logic [4:0]  comp_q;
  logic [4:0]  comp_d;
  logic        atk_run;
  logic        rel_run;
  logic        atk_tick;
  logic        rel_tick;
  logic        attacking;

  assign attacking = (state_q == ST_ATTACK) || (state_q == ST_ADJUST);
  assign atk_run = enabled && attacking && over_limit;
  assign rel_run = enabled && (state_q == ST_RELEASE) && !over_limit;

  step_timer #(.CYCLES(ATTACK_CYC)) u_attack_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (atk_run),
    .tick    (atk_tick)
  );

  step_timer #(.CYCLES(RELEASE_CYC)) u_release_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (rel_run),
    .tick    (rel_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Compressor

  always_comb begin
    state_d = state_q;
    comp_d  = comp_q;
    if (!enabled) begin
      state_d = ST_IDLE;
      comp_d  = '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (over_limit) begin
            state_d = ST_ATTACK;
          end
        end
        ST_ATTACK, ST_ADJUST: begin
          if (!over_limit) begin
            state_d = (comp_q == '0) ? ST_IDLE : ST_RELEASE;
          end else if (comp_q >= COMP_MAX_HALF_DB) begin
            // Park at the floor so the timers stay quiet
            state_d = ST_HOLD;
          end else if (atk_tick) begin
            // Adjusting uses half steps, attack full steps
            if (state_q == ST_ADJUST) begin
              comp_d = comp_q + STEP_HALF_HALF_DB;
            end else begin
              comp_d = comp_q + STEP_FULL_HALF_DB;
            end
            if (comp_d > COMP_MAX_HALF_DB) begin
              comp_d = COMP_MAX_HALF_DB;
            end
          end
        end
        ST_HOLD: begin
          if (!over_limit) begin
            state_d = ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (over_limit) begin
            state_d = ST_ADJUST;
          end else if (rel_tick) begin
            comp_d = comp_q - STEP_HALF_HALF_DB;
            if (comp_d == '0) begin
              state_d = ST_IDLE;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
          comp_d  = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      comp_q  <= '0;
    end else begin
      state_q <= state_d;
      comp_q  <= comp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, registered

  ctl_status_t status_d;
  ctl_status_t status_q;
  logic        amp_en_q;

  always_comb begin
    status_d.mode         = mode;
    status_d.gain         = gain;
    status_d.trip_index   = trip_sel;
    status_d.comp_half_db = comp_d;
    status_d.state        = state_d;
    status_d.limiting     = limiting && enabled;
    status_d.amp_enable   = !shutdown;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= '0;
      amp_en_q <= 1'b0;
    end else begin
      status_q <= status_d;
      amp_en_q <= !shutdown;
    end
  end

  assign status                 = status_q;
  assign gain_reduction_half_db = status_q.comp_half_db;
  assign amp_enable             = amp_en_q;

endmodule : amp_gain_limiter_control
`default_nettype wire

// file: logic/amp_limit_pkg.sv
package amp_limit_pkg;

  // Strap decode results
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_SUPPLY = 2'h1,
    MODE_LEVEL  = 2'h2
  } limit_mode_t;

  typedef enum logic [1:0] {
    GAIN_6DB    = 2'h0,
    GAIN_15P5DB = 2'h1,
    GAIN_20DB   = 2'h2
  } gain_sel_t;

  // Compressor states, Gray along idle-attack-hold-release-adjust
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_ATTACK  = 3'h1,
    ST_HOLD    = 3'h3,
    ST_RELEASE = 3'h2,
    ST_ADJUST  = 3'h6
  } comp_state_t;

  // Analog front end flags, one bit each
  typedef struct packed {
    logic strap_at_supply;  // limit_mode_strap tied to supply
    logic strap_at_ground;  // limit_mode_strap tied to ground
    logic gain_strap_high;
    logic gain_strap_low;
    logic supply_below_trip;
    logic swing_over_supply_limit;
    logic swing_over_rail_limit; // 90 % of boosted_rail_voltage
  } afe_flags_t;

  typedef struct packed {
    limit_mode_t mode;
    gain_sel_t   gain;
    logic [3:0]  trip_index;
    logic [4:0]  comp_half_db;
    comp_state_t state;
    logic        limiting;
    logic        amp_enable;
  } ctl_status_t;

  localparam int CLK_HZ            = 100_000_000;
  localparam int ATTACK_STEP_US    = 20;
  localparam int RELEASE_STEP_MS   = 800;
  localparam int ATTACK_CYCLES     = CLK_HZ / 1_000_000 * ATTACK_STEP_US;
  localparam int RELEASE_CYCLES    = CLK_HZ / 1000 * RELEASE_STEP_MS;
  localparam logic [4:0] COMP_MAX_HALF_DB  = 5'h0c;
  localparam logic [4:0] STEP_FULL_HALF_DB = 5'h02;
  localparam logic [4:0] STEP_HALF_HALF_DB = 5'h01;
  localparam int TRIP_ENTRIES      = 11;

  // Trip voltage per resistor index, 10 mV units, 20.0 kohm ... 82.0 kohm
  localparam logic [9:0] TRIP_10MV [TRIP_ENTRIES] = '{
    10'h172, 10'h168, 10'h163, 10'h15e, 10'h154, 10'h14a,
    10'h140, 10'h136, 10'h12c, 10'h122, 10'h118
  };

endpackage : amp_limit_pkg

// file: logic/step_timer.sv
`timescale 1ns/1ps
`default_nettype none
module step_timer
  import amp_limit_pkg::*;
#(
  parameter int CYCLES = 2000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic run,
  output logic      tick
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (!run) begin
      cnt_d = '0;
    end else if (cnt_q == LAST) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Restarts whenever run drops, so each step waits a full period
  assign tick = run && (cnt_q == LAST);

endmodule : step_timer
`default_nettype wire

// file: verif/amp_limit_sva.sv
`timescale 1ns/1ps
`default_nettype none
module amp_limit_sva
  import amp_limit_pkg::*;
#(
  parameter int ATTACK_CYC = ATTACK_CYCLES
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Pins
  input wire afe_flags_t  afe_flags,
  input wire logic [3:0]  trip_resistor_index,
  input wire logic        regulator_off_n,
  input wire logic        amplifier_off_n,
  // Results
  input wire ctl_status_t status,
  input wire logic [4:0]  gain_reduction_half_db,
  input wire logic        amp_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  localparam int FULL = ATTACK_CYC * 12 + 20;
  wire logic [4:0] g   = gain_reduction_half_db;
  wire logic       off = !regulator_off_n && !amplifier_off_n;
  wire logic       lvl = afe_flags.strap_at_ground && !off &&
                         !afe_flags.strap_at_supply &&
                         afe_flags.swing_over_rail_limit;
  ////////////////////////////////////////////////////////////////////
  // Cycles of unbroken over-limit level mode, saturating
  // Wide enough for the full-rate attack period as well
  logic [15:0] run_q;
  logic [15:0] run_d;
  always_comb begin
    run_d = 16'h0000;
    if (lvl) begin
      run_d = (run_q == 16'(FULL)) ? run_q : run_q + 16'h0001;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) run_q <= 16'h0000;
    else run_q <= run_d;
  end
  ////////////////////////////////////////////////////////////////////
  a_shutdown_off: assert property (off [*5] |-> !amp_enable)
    else $error("amplifier enabled in shutdown");
  a_comp_bound: assert property (g <= 5'h0c)
    else $error("compression past floor");
  a_step_up: assert property (g > $past(g) |-> g - $past(g) <= 5'h02)
    else $error("attack step too large");
  a_step_down: assert property (g < $past(g) |->
    g == $past(g) - 5'h01 || g == 5'h00)
    else $error("release step wrong");
  a_attack_gap: assert property (g > $past(g) |=> (g <= $past(g)) [*8])
    else $error("attack steps too close");
  a_off_clear: assert property (
    (off || afe_flags.strap_at_supply) [*5] |-> g == 5'h00)
    else $error("compression kept while disabled");
  a_level_attack: assert property (run_q == 16'(ATTACK_CYC + 20)
    |-> g != 5'h00)
    else $error("level mode did not attack");
  a_attack_floor: assert property (run_q == FULL |-> g == 5'h0c)
    else $error("attack stopped short of floor");
  a_supply_quiet: assert property ((status.mode == MODE_SUPPLY &&
    !afe_flags.supply_below_trip) [*5] |-> g <= $past(g))
    else $error("attack above trip voltage");
  c_floor: cover property (g == 5'h0c);
  c_release: cover property (g < $past(g) && g != 5'h00);
  c_shut: cover property ($fell(amp_enable));
endmodule : amp_limit_sva
bind amp_gain_limiter_control amp_limit_sva #(.ATTACK_CYC(ATTACK_CYC)) chk (
  .clk(clk), .sys_rst(sys_rst), .afe_flags(afe_flags),
  .trip_resistor_index(trip_resistor_index),
  .regulator_off_n(regulator_off_n), .amplifier_off_n(amplifier_off_n),
  .status(status), .gain_reduction_half_db(gain_reduction_half_db),
  .amp_enable(amp_enable));
`default_nettype wire

// file: verif/host_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_pins_model
  import amp_limit_pkg::*;
(
  // Host choices: strap 0 supply 1 resistor 2 ground; gain 0 low 2 high
  input  wire logic [1:0] strap,
  input  wire logic [1:0] gain_lvl,
  input  wire logic       below,
  input  wire logic       over,
  input  wire logic [1:0] shut,
  // Pins as the block sees them
  output afe_flags_t      afe_flags,
  output logic            regulator_off_n,
  output logic            amplifier_off_n
);
  assign afe_flags = {strap == 2'h0, strap == 2'h2, gain_lvl == 2'h2,
                      gain_lvl == 2'h0, below, over, over};
  // Full logic levels only, never mid-rail
  assign regulator_off_n = !shut[1];
  assign amplifier_off_n = !shut[0];
endmodule : host_pins_model
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import amp_limit_pkg::*;
;
  logic        clk = 1'b0, sys_rst = 1'b1, below = 1'b0, over = 1'b0;
  logic [1:0]  strap = 2'h2, gl = 2'h1, shut = 2'h0;
  logic [3:0]  trip = 4'h0;
  logic [31:0] seed = 32'h2e32;
  int          bad_count = 0, n_checks = 0;
  afe_flags_t  flags;
  ctl_status_t st;
  logic [4:0]  g;
  logic        rn, an, en;
  always #5 clk = ~clk;
  host_pins_model pm (.strap(strap), .gain_lvl(gl), .below(below),
    .over(over), .shut(shut), .afe_flags(flags), .regulator_off_n(rn),
    .amplifier_off_n(an));
  amp_gain_limiter_control #(.ATTACK_CYC(20), .RELEASE_CYC(50)) uut (
    .clk(clk), .sys_rst(sys_rst), .afe_flags(flags),
    .trip_resistor_index(trip), .regulator_off_n(rn),
    .amplifier_off_n(an), .status(st), .gain_reduction_half_db(g),
    .amp_enable(en));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic limit_mode_t xm(input logic [1:0] s);
    return s == 2'h0 ? MODE_OFF : (s == 2'h2 ? MODE_LEVEL : MODE_SUPPLY);
  endfunction : xm
  function automatic gain_sel_t xg(input logic [1:0] s);
    return s == 2'h0 ? GAIN_6DB : (s == 2'h2 ? GAIN_20DB : GAIN_15P5DB);
  endfunction : xg
  function automatic logic xl(input logic [1:0] s, input logic b,
                              input logic [1:0] sh);
    return sh != 2'h3 && (s == 2'h2 || (s != 2'h0 && b));
  endfunction : xl
  task automatic cmp(input logic [4:0] got, input logic [4:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////
  initial begin
    wt(10);
    cmp({4'h0, en}, 5'h00);
    wt(10);
    sys_rst = 1'b0;
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 3; k++) begin
        strap = 2'(m);
        gl = 2'(k);
        wt(6);
        cmp({3'h0, st.mode}, {3'h0, xm(strap)});
        cmp({3'h0, st.gain}, {3'h0, xg(gl)});
      end
    end
    over = 1'b1;
    wt(30);
    cmp(g, 5'h02);
    for (int i = 0; i < 400 && g !== 5'h0c; i++) wt(1);
    cmp(g, 5'h0c);
    wt(100);
    cmp(g, 5'h0c);
    cmp({2'h0, st.state}, {2'h0, ST_HOLD});
    over = 1'b0;
    wt(175);
    cmp(g, 5'h09);
    cmp({2'h0, st.state}, {2'h0, ST_RELEASE});
    over = 1'b1;
    wt(30);
    cmp(g, 5'h0a);
    cmp({2'h0, st.state}, {2'h0, ST_ADJUST});
    for (int s = 3; s >= 0; s--) begin
      shut = 2'(s);
      wt(6);
      cmp({4'h0, en}, {4'h0, s != 3});
    end
    cmp(g, 5'h00);
    wt(40);
    strap = 2'h0;
    wt(6);
    cmp(g, 5'h00);
    strap = 2'h1;
    wt(60);
    cmp(g, 5'h00);
    below = 1'b1;
    wt(30);
    cmp(g, 5'h02);
    repeat (40) begin
      seed = xs(seed);
      {trip, shut, over, below, gl, strap} = seed[11:0];
      wt(25);
      cmp({1'b0, st.trip_index}, {1'b0, trip > 4'ha ? 4'ha : trip});
      cmp({4'h0, g > 5'h0c}, 5'h00);
      cmp({3'h0, st.mode}, {3'h0, xm(strap)});
      cmp({3'h0, st.gain}, {3'h0, xg(gl)});
      cmp({4'h0, en}, {4'h0, shut != 2'h3});
      cmp({4'h0, st.amp_enable}, {4'h0, shut != 2'h3});
      cmp({4'h0, st.limiting}, {4'h0, xl(strap, below, shut)});
      cmp(st.comp_half_db, g);
    end
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
